// ### logic/ppt_top.sv
// four-port control-0 register bank with per-port priority and tag control
// Contract
// - each of the four ports has its own identically laid out control-0 register at 0x20, 0x30, 0x40 and 0x50.
// - bit 7 set applies broadcast storm protection to frames arriving on the port.
// - bit 6 set classifies ingress frames by their DiffServ code point.
// - bit 5 set classifies ingress frames by their 802.1p priority field.
// - bits 4 to 3 give the priority 0 to 3 used when no enabled classifier can classify a frame.
// - with several classifiers active the OR of the 802.1p and code point priorities replaces the port priority.
// - bit 2 set adds a tag carrying the ingress port default VID to frames received untagged.
// - with insertion on, frames received tagged get no extra tag.
// - bit 1 set strips the tag from frames received tagged.
// - with removal on, frames received untagged leave unchanged.
// - bit 0 with the global upper bit selects one, two or four output queues, code 11 reserved.
// - with one output queue there is no priority differentiation.
// - the inserted VID comes from the ingress port default tag register.
`timescale 1ns/100ps
`include "ppt_defines.svh"
module ppt_top #(
  parameter int NPORT = 4                       // number of switch ports
) (
  input  wire logic                 i_clk,           // core clock, 40 MHz
  input  wire logic                 i_rst_n,         // async reset, active low
  input  wire logic [7:0]           i_reg_addr,      // management register address
  input  wire logic                 i_reg_wr,        // write strobe, one cycle
  input  wire logic [7:0]           i_reg_wdata,     // write data
  input  wire logic                 i_reg_rd,        // read strobe, one cycle
  output logic [7:0]                o_reg_rdata,     // read data
  output logic                      o_reg_rvld,      // read data valid pulse
  input  wire logic [NPORT-1:0]     i_glb_split_hi,  // global upper split bit per port
  input  wire logic [NPORT*16-1:0]  i_dflt_tag,      // default tag of each port
  input  wire logic [NPORT-1:0]     i_ing_vld,       // ingress descriptor valid
  input  wire logic [NPORT-1:0]     i_ing_bcast,     // ingress broadcast
  input  wire logic [NPORT-1:0]     i_ing_dscp_ok,   // code point usable
  input  wire logic [NPORT*2-1:0]   i_ing_dscp_pri,  // code point priority
  input  wire logic [NPORT-1:0]     i_ing_tagged,    // 802.1p field usable
  input  wire logic [NPORT*2-1:0]   i_ing_pcp_pri,   // 802.1p priority
  input  wire logic [NPORT-1:0]     i_egr_vld,       // egress descriptor valid
  input  wire logic [NPORT-1:0]     i_egr_rx_tagged, // frame tagged on reception
  input  wire logic [NPORT*2-1:0]   i_egr_pri,       // frame priority
  input  wire logic [NPORT*2-1:0]   i_egr_src,       // ingress port of the frame
  output logic [NPORT-1:0]          o_ing_vld,       // ingress result valid
  output logic [NPORT*2-1:0]        o_ing_pri,       // ingress priority
  output logic [NPORT-1:0]          o_storm_chk,     // storm protection applies
  output logic [NPORT-1:0]          o_egr_vld,       // egress result valid
  output logic [NPORT-1:0]          o_egr_ins,       // insert tag
  output logic [NPORT-1:0]          o_egr_strip,     // strip tag
  output logic [NPORT*12-1:0]       o_egr_vid,       // VID to insert
  output logic [NPORT*2-1:0]        o_egr_q          // output queue
);

  logic                   rst_meta_ff;
  logic                   rst_sync_ff;
  ppt_pkg::ppt_ctrl_t     ctrl_ff [NPORT];
  logic                   wr_hit;
  logic [1:0]             wr_idx;
  logic                   rd_hit;
  logic [1:0]             rd_idx;

  // reset enters asynchronously, released through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // decodes a port control-0 address; the low nibble must be zero
  function automatic logic [2:0] ppt_port_sel(input logic [7:0] addr);
    logic [2:0] res;
    res = 3'h0;
    if (addr[3:0] == 4'h0 && addr >= `PPT_OFS_PORT1 && addr <= `PPT_OFS_PORT4) begin
      res = {1'b1, 2'(3'(addr[7:4]) - 3'h2)};
    end
    return res;
  endfunction : ppt_port_sel

  assign {wr_hit, wr_idx} = ppt_port_sel(i_reg_addr);
  assign {rd_hit, rd_idx} = ppt_port_sel(i_reg_addr);

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_reg
      always_ff @(posedge i_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
          ctrl_ff[p] <= `PPT_CTRL_RST;
        end else if (i_reg_wr && wr_hit && wr_idx == 2'(p)) begin
          ctrl_ff[p] <= i_reg_wdata;
        end
      end
    end
  endgenerate

  // reserved and unmapped addresses read as zero, writes to them are dropped
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_reg_rdata <= `PPT_RD_ZERO;
      o_reg_rvld  <= 1'b0;
    end else begin
      o_reg_rvld  <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_hit ? ctrl_ff[rd_idx] : `PPT_RD_ZERO;
      end
    end
  end

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      ppt_ctl_if   u_ctl ();
      logic [1:0]  src;
      logic [11:0] vid;

      assign u_ctl.ctrl         = ctrl_ff[p];
      assign u_ctl.glb_split_hi = i_glb_split_hi[p];
      assign src                = i_egr_src[p*2 +: 2];
      // VID of the frame's ingress port, not of this egress port
      assign vid                = i_dflt_tag[{src, 4'h0} +: 12];

      ppt_port u_port (
        .i_clk           (i_clk),
        .i_rst_n         (rst_sync_ff),
        .ctl             (u_ctl),
        .i_ing_vld       (i_ing_vld[p]),
        .i_ing_bcast     (i_ing_bcast[p]),
        .i_ing_dscp_ok   (i_ing_dscp_ok[p]),
        .i_ing_dscp_pri  (i_ing_dscp_pri[p*2 +: 2]),
        .i_ing_tagged    (i_ing_tagged[p]),
        .i_ing_pcp_pri   (i_ing_pcp_pri[p*2 +: 2]),
        .i_egr_vld       (i_egr_vld[p]),
        .i_egr_rx_tagged (i_egr_rx_tagged[p]),
        .i_egr_pri       (i_egr_pri[p*2 +: 2]),
        .i_egr_vid       (vid),
        .o_ing_vld       (o_ing_vld[p]),
        .o_ing_pri       (o_ing_pri[p*2 +: 2]),
        .o_storm_chk     (o_storm_chk[p]),
        .o_egr_vld       (o_egr_vld[p]),
        .o_egr_ins       (o_egr_ins[p]),
        .o_egr_strip     (o_egr_strip[p]),
        .o_egr_vid       (o_egr_vid[p*12 +: 12]),
        .o_egr_q         (o_egr_q[p*2 +: 2])
      );
    end
  endgenerate

  AST_RD_BACK: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_reg_wr && wr_hit) ##1 (i_reg_rd && i_reg_addr == $past(i_reg_addr) && !i_reg_wr)
      |=> o_reg_rvld && o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("read back differs from write");

  AST_RSVD_ZERO: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_reg_rd && !rd_hit) |=> o_reg_rvld && o_reg_rdata == `PPT_RD_ZERO)
    else $error("unmapped read not zero");

  AST_RST_ZERO: assert property (@(posedge i_clk)
    $rose(rst_sync_ff) |-> ctrl_ff[0] == `PPT_CTRL_RST && ctrl_ff[1] == `PPT_CTRL_RST
      && ctrl_ff[2] == `PPT_CTRL_RST && ctrl_ff[3] == `PPT_CTRL_RST)
    else $error("control not zero after reset");

  AST_DSCP_ONLY: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_ing_vld[0] && ctrl_ff[0][`PPT_BIT_DSCP] && i_ing_dscp_ok[0]
      && !ctrl_ff[0][`PPT_BIT_DOT1P]) |=> o_ing_pri[1:0] == $past(i_ing_dscp_pri[1:0]))
    else $error("code point priority not applied");

  AST_PCP_ONLY: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_ing_vld[1] && ctrl_ff[1][`PPT_BIT_DOT1P] && i_ing_tagged[1]
      && !ctrl_ff[1][`PPT_BIT_DSCP]) |=> o_ing_pri[3:2] == $past(i_ing_pcp_pri[3:2]))
    else $error("802.1p priority not applied");

  AST_VID_SRC: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    i_egr_vld[2] |=> o_egr_vid[35:24] == $past(g_port[2].vid))
    else $error("inserted VID not from ingress port");

  AST_RVLD_HI: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    i_reg_rd |=> o_reg_rvld)
    else $error("read valid missing");

  AST_RVLD_LO: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    !i_reg_rd |=> !o_reg_rvld)
    else $error("read valid without read");

  AST_RDATA_HOLD: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");

  // a control word changes only through a decoded write to its own address
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_chk
      AST_CTRL_LAND: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
        (i_reg_wr && wr_hit && wr_idx == 2'(p)) |=> ctrl_ff[p] == $past(i_reg_wdata))
        else $error("write did not land");

      AST_CTRL_HOLD: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
        !(i_reg_wr && wr_hit && wr_idx == 2'(p)) |=> $stable(ctrl_ff[p]))
        else $error("control changed without write");
    end
  endgenerate

  AST_TWO_Q: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_egr_vld[3] && !i_glb_split_hi[3] && ctrl_ff[3][`PPT_BIT_SPLIT_LO])
      |=> o_egr_q[7:6] == {1'b0, $past(i_egr_pri[7])})
    else $error("two queue mapping wrong");

  AST_RSVD_Q: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_egr_vld[3] && i_glb_split_hi[3] && ctrl_ff[3][`PPT_BIT_SPLIT_LO]) |=> o_egr_q[7:6] == 2'h0)
    else $error("reserved split code not single queue");

  AST_NO_STORM: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_ing_vld[2] && !ctrl_ff[2][`PPT_BIT_STORM]) |=> !o_storm_chk[2])
    else $error("storm check while disabled");

  AST_NO_CLASS: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_ing_vld[2] && !ctrl_ff[2][`PPT_BIT_DSCP] && !ctrl_ff[2][`PPT_BIT_DOT1P])
      |=> o_ing_pri[5:4] == $past(ctrl_ff[2][`PPT_BIT_PPRI_HI:`PPT_BIT_PPRI_LO]))
    else $error("disabled classifier still used");

  AST_NO_INS: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_egr_vld[1] && !ctrl_ff[1][`PPT_BIT_TAG_INS]) |=> !o_egr_ins[1])
    else $error("tag inserted while disabled");

  AST_NO_STRIP: assert property (@(posedge i_clk) disable iff (!rst_sync_ff)
    (i_egr_vld[1] && !ctrl_ff[1][`PPT_BIT_TAG_RMV]) |=> !o_egr_strip[1])
    else $error("tag stripped while disabled");

  CVR_WR_P4: cover property (@(posedge i_clk) disable iff (!rst_sync_ff)
    i_reg_wr && i_reg_addr == `PPT_OFS_PORT4);
  CVR_STRIP: cover property (@(posedge i_clk) disable iff (!rst_sync_ff) |o_egr_strip);

endmodule : ppt_top

// ### logic/ppt_defines.svh
// register offsets, field positions and reset values of the port control-0 bank
`ifndef PPT_DEFINES_SVH
`define PPT_DEFINES_SVH

`define PPT_OFS_RSVD_A     8'h10
`define PPT_OFS_RSVD_B     8'h11
`define PPT_OFS_PORT1      8'h20
`define PPT_OFS_PORT2      8'h30
`define PPT_OFS_PORT3      8'h40
`define PPT_OFS_PORT4      8'h50
`define PPT_OFS_STEP       8'h10

`define PPT_BIT_STORM      7
`define PPT_BIT_DSCP       6
`define PPT_BIT_DOT1P      5
`define PPT_BIT_PPRI_HI    4
`define PPT_BIT_PPRI_LO    3
`define PPT_BIT_TAG_INS    2
`define PPT_BIT_TAG_RMV    1
`define PPT_BIT_SPLIT_LO   0

`define PPT_CTRL_RST       8'h00
`define PPT_RD_ZERO        8'h00

`endif

// ### logic/ppt_pkg.sv
// types shared by the port control-0 bank
package ppt_pkg;

  // order matches the two-bit {global, port} split code
  typedef enum logic [1:0] {
    PPT_SPLIT_ONE,
    PPT_SPLIT_TWO,
    PPT_SPLIT_FOUR,
    PPT_SPLIT_RSVD
  } ppt_split_t;

  typedef logic [7:0] ppt_ctrl_t;

endpackage : ppt_pkg

// ### logic/ppt_ctl_if.sv
// control bits handed from the register bank to one port
`timescale 1ns/100ps
interface ppt_ctl_if;
  ppt_pkg::ppt_ctrl_t ctrl;          // port control-0 contents
  logic               glb_split_hi;  // global upper split bit

  modport src (output ctrl, output glb_split_hi);
  modport dst (input ctrl, input glb_split_hi);
endinterface : ppt_ctl_if

// ### logic/ppt_port.sv
// per-port ingress classification and egress tag and queue decisions
`timescale 1ns/100ps
`include "ppt_defines.svh"
module ppt_port (
  input  wire logic        i_clk,           // core clock
  input  wire logic        i_rst_n,         // synchronised reset
  ppt_ctl_if.dst           ctl,             // control bits
  input  wire logic        i_ing_vld,       // ingress frame descriptor valid
  input  wire logic        i_ing_bcast,     // frame is broadcast
  input  wire logic        i_ing_dscp_ok,   // frame has a usable code point
  input  wire logic [1:0]  i_ing_dscp_pri,  // priority mapped from code point
  input  wire logic        i_ing_tagged,    // frame carries a usable 802.1p field
  input  wire logic [1:0]  i_ing_pcp_pri,   // priority mapped from 802.1p field
  input  wire logic        i_egr_vld,       // egress frame descriptor valid
  input  wire logic        i_egr_rx_tagged, // frame was tagged on reception
  input  wire logic [1:0]  i_egr_pri,       // classified priority of the frame
  input  wire logic [11:0] i_egr_vid,       // ingress port default VID
  output logic             o_ing_vld,       // ingress result valid
  output logic [1:0]       o_ing_pri,       // ingress priority
  output logic             o_storm_chk,     // storm protection applies
  output logic             o_egr_vld,       // egress result valid
  output logic             o_egr_ins,       // insert a tag
  output logic             o_egr_strip,     // strip the tag
  output logic [11:0]      o_egr_vid,       // VID to insert
  output logic [1:0]       o_egr_q          // output queue index
);

  ppt_pkg::ppt_split_t split;
  logic                use_dscp;
  logic                use_pcp;
  logic [1:0]          nxt_pri;

  assign split    = ppt_pkg::ppt_split_t'({ctl.glb_split_hi, ctl.ctrl[`PPT_BIT_SPLIT_LO]});
  assign use_dscp = ctl.ctrl[`PPT_BIT_DSCP] & i_ing_dscp_ok;
  assign use_pcp  = ctl.ctrl[`PPT_BIT_DOT1P] & i_ing_tagged;

  always_comb begin
    nxt_pri = ctl.ctrl[`PPT_BIT_PPRI_HI:`PPT_BIT_PPRI_LO];
    if (use_dscp || use_pcp) begin
      // both classifiers merge by OR in place of the port default
      nxt_pri = ({2{use_dscp}} & i_ing_dscp_pri) | ({2{use_pcp}} & i_ing_pcp_pri);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ing_vld   <= 1'b0;
      o_ing_pri   <= 2'h0;
      o_storm_chk <= 1'b0;
    end else begin
      o_ing_vld   <= i_ing_vld;
      o_ing_pri   <= i_ing_vld ? nxt_pri : 2'h0;
      o_storm_chk <= i_ing_vld & i_ing_bcast & ctl.ctrl[`PPT_BIT_STORM];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_egr_vld   <= 1'b0;
      o_egr_ins   <= 1'b0;
      o_egr_strip <= 1'b0;
      o_egr_vid   <= 12'h000;
    end else begin
      o_egr_vld   <= i_egr_vld;
      o_egr_ins   <= i_egr_vld & ctl.ctrl[`PPT_BIT_TAG_INS] & ~i_egr_rx_tagged;
      o_egr_strip <= i_egr_vld & ctl.ctrl[`PPT_BIT_TAG_RMV] & i_egr_rx_tagged;
      o_egr_vid   <= i_egr_vid;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_egr_q <= 2'h0;
    end else if (!i_egr_vld) begin
      o_egr_q <= 2'h0;
    end else begin
      unique case (split)
        ppt_pkg::PPT_SPLIT_ONE:  o_egr_q <= 2'h0;
        ppt_pkg::PPT_SPLIT_TWO:  o_egr_q <= {1'b0, i_egr_pri[1]};
        ppt_pkg::PPT_SPLIT_FOUR: o_egr_q <= i_egr_pri;
        ppt_pkg::PPT_SPLIT_RSVD: o_egr_q <= 2'h0; // reserved code falls back to one queue
      endcase
    end
  end

  AST_STORM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_storm_chk |-> $past(ctl.ctrl[`PPT_BIT_STORM]) && $past(i_ing_bcast))
    else $error("storm check without enable");

  AST_PORT_PRI: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ing_vld && !use_dscp && !use_pcp)
      |=> o_ing_pri == $past(ctl.ctrl[`PPT_BIT_PPRI_HI:`PPT_BIT_PPRI_LO]))
    else $error("port default priority not used");

  AST_OR_PRI: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ing_vld && use_dscp && use_pcp) |=> o_ing_pri == ($past(i_ing_dscp_pri) | $past(i_ing_pcp_pri)))
    else $error("merged priority wrong");

  AST_INS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_egr_vld && ctl.ctrl[`PPT_BIT_TAG_INS] && !i_egr_rx_tagged) |=> o_egr_ins)
    else $error("tag not inserted");

  AST_NO_DOUBLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_egr_vld && i_egr_rx_tagged) |=> !o_egr_ins)
    else $error("second tag inserted");

  AST_STRIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_egr_vld && ctl.ctrl[`PPT_BIT_TAG_RMV] && i_egr_rx_tagged) |=> o_egr_strip)
    else $error("tag not stripped");

  AST_UNTAG_KEEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_egr_vld && !i_egr_rx_tagged) |=> !o_egr_strip)
    else $error("untagged frame modified");

  AST_ONE_Q: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_egr_vld && split == ppt_pkg::PPT_SPLIT_ONE) |=> o_egr_q == 2'h0)
    else $error("single queue mode used another queue");

  AST_FOUR_Q: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_egr_vld && split == ppt_pkg::PPT_SPLIT_FOUR) |=> o_egr_q == $past(i_egr_pri))
    else $error("four queue mapping wrong");

  CVR_OR_PRI: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ing_vld && use_dscp && use_pcp);
  CVR_INS: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_egr_ins);
  CVR_TWO_Q: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_egr_vld && split == ppt_pkg::PPT_SPLIT_TWO && i_egr_pri[1]);

endmodule : ppt_port

// ### bench/ppt_testbench.sv
// self-checking bench for the four-port control-0 register bank
`timescale 1ns/100ps
module testbench;
  logic         i_clk = 1'b0;
  logic         i_rst_n = 1'b0;
  logic [7:0]   i_reg_addr = 8'h00;
  logic         i_reg_wr = 1'b0;
  logic [7:0]   i_reg_wdata = 8'h00;
  logic         i_reg_rd = 1'b0;
  logic [3:0]   i_glb_split_hi = 4'h0;
  logic [63:0]  i_dflt_tag = 64'h0;
  logic [3:0]   i_ing_vld = 4'h0;
  logic [3:0]   i_ing_bcast = 4'h0;
  logic [3:0]   i_ing_dscp_ok = 4'h0;
  logic [7:0]   i_ing_dscp_pri = 8'h00;
  logic [3:0]   i_ing_tagged = 4'h0;
  logic [7:0]   i_ing_pcp_pri = 8'h00;
  logic [3:0]   i_egr_vld = 4'h0;
  logic [3:0]   i_egr_rx_tagged = 4'h0;
  logic [7:0]   i_egr_pri = 8'h00;
  logic [7:0]   i_egr_src = 8'h00;
  logic [7:0]   o_reg_rdata;
  logic         o_reg_rvld;
  logic [3:0]   o_ing_vld, o_storm_chk, o_egr_vld, o_egr_ins, o_egr_strip;
  logic [7:0]   o_ing_pri, o_egr_q;
  logic [47:0]  o_egr_vid;
  logic [31:0]  seed = 32'h00000013;
  logic [7:0]   ctl [4];
  int           fail_count = 0;
  int           comparisons = 0;

  always #12.5 i_clk = ~i_clk;

  ppt_top #(.NPORT(4)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvld(o_reg_rvld), .i_glb_split_hi(i_glb_split_hi), .i_dflt_tag(i_dflt_tag),
    .i_ing_vld(i_ing_vld), .i_ing_bcast(i_ing_bcast), .i_ing_dscp_ok(i_ing_dscp_ok),
    .i_ing_dscp_pri(i_ing_dscp_pri), .i_ing_tagged(i_ing_tagged),
    .i_ing_pcp_pri(i_ing_pcp_pri), .i_egr_vld(i_egr_vld), .i_egr_rx_tagged(i_egr_rx_tagged),
    .i_egr_pri(i_egr_pri), .i_egr_src(i_egr_src), .o_ing_vld(o_ing_vld),
    .o_ing_pri(o_ing_pri), .o_storm_chk(o_storm_chk), .o_egr_vld(o_egr_vld),
    .o_egr_ins(o_egr_ins), .o_egr_strip(o_egr_strip), .o_egr_vid(o_egr_vid),
    .o_egr_q(o_egr_q)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [1:0] exp_pri(input logic [7:0] c, input logic dok,
                                         input logic [1:0] dp, input logic tg,
                                         input logic [1:0] pp);
    logic ud;
    logic up;
    ud = c[6] & dok;
    up = c[5] & tg;
    if (ud | up) return (ud ? dp : 2'h0) | (up ? pp : 2'h0);
    return c[4:3];
  endfunction : exp_pri

  // reserved split code behaves as a single queue
  function automatic logic [1:0] exp_q(input logic [7:0] c, input logic glb,
                                       input logic [1:0] pri);
    case ({glb, c[0]})
      2'h1: return {1'b0, pri[1]};
      2'h2: return pri;
      default: return 2'h0;
    endcase
  endfunction : exp_q

  task automatic cyc();
    @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (e !== g) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  // strobe drops and one edge passes, so back-to-back calls never retoggle in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc();
    i_reg_wr = 1'b0;
    cyc();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cyc();
    i_reg_rd = 1'b0;
    chk("rvld", 12'h1, {11'h0, o_reg_rvld});
    chk("rdata", {4'h0, e}, {4'h0, o_reg_rdata});
    cyc();
    chk("rvld_pulse", 12'h0, {11'h0, o_reg_rvld});
  endtask : rd

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic drive();
    logic [31:0] r0;
    logic [31:0] r1;
    r0 = rnd();
    r1 = rnd();
    {i_ing_vld, i_ing_bcast, i_ing_dscp_ok, i_ing_tagged, i_ing_dscp_pri, i_ing_pcp_pri} = r0;
    {i_egr_vld, i_egr_rx_tagged, i_glb_split_hi, i_egr_pri, i_egr_src} = r1[27:0];
    i_dflt_tag = {rnd(), rnd()};
  endtask : drive

  task automatic check_ports();
    logic iv;
    logic ev;
    logic rt;
    logic [1:0] ep;
    for (int p = 0; p < 4; p++) begin
      iv = i_ing_vld[p];
      ev = i_egr_vld[p];
      rt = i_egr_rx_tagged[p];
      ep = exp_pri(ctl[p], i_ing_dscp_ok[p], i_ing_dscp_pri[p*2 +: 2], i_ing_tagged[p],
                   i_ing_pcp_pri[p*2 +: 2]);
      chk("ing_vld", {11'h0, iv}, {11'h0, o_ing_vld[p]});
      chk("ing_pri", iv ? {10'h0, ep} : 12'h0, {10'h0, o_ing_pri[p*2 +: 2]});
      chk("storm", {11'h0, iv & i_ing_bcast[p] & ctl[p][7]}, {11'h0, o_storm_chk[p]});
      chk("egr_vld", {11'h0, ev}, {11'h0, o_egr_vld[p]});
      chk("egr_ins", {11'h0, ev & ctl[p][2] & ~rt}, {11'h0, o_egr_ins[p]});
      chk("egr_strip", {11'h0, ev & ctl[p][1] & rt}, {11'h0, o_egr_strip[p]});
      chk("egr_vid", i_dflt_tag[int'(i_egr_src[p*2 +: 2])*16 +: 12], o_egr_vid[p*12 +: 12]);
      chk("egr_q", ev ? {10'h0, exp_q(ctl[p], i_glb_split_hi[p], i_egr_pri[p*2 +: 2])} : 12'h0,
          {10'h0, o_egr_q[p*2 +: 2]});
    end
  endtask : check_ports

  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (3) cyc();
    i_rst_n = 1'b1;
    repeat (3) cyc();
    for (int p = 0; p < 4; p++) rd(8'h20 + {2'(p), 4'h0}, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h21, 8'h5A);
    rd(8'h20, 8'h00);
    rd(8'h11, 8'h00);
    for (int p = 0; p < 4; p++) begin
      ctl[p] = 8'(rnd());
      wr(8'h20 + {2'(p), 4'h0}, ctl[p]);
    end
    for (int p = 0; p < 4; p++) rd(8'h20 + {2'(p), 4'h0}, ctl[p]);
    // write and read in one cycle: the read sees the old contents
    i_reg_addr = 8'h30;
    i_reg_wdata = ~ctl[1];
    i_reg_wr = 1'b1;
    i_reg_rd = 1'b1;
    cyc();
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    chk("rdata_old", {4'h0, ctl[1]}, {4'h0, o_reg_rdata});
    ctl[1] = ~ctl[1];
    cyc();
    rd(8'h30, ctl[1]);
    // write then read on the very next edge: the read sees the new contents
    ctl[2] = 8'hA5;
    i_reg_addr = 8'h40;
    i_reg_wdata = ctl[2];
    i_reg_wr = 1'b1;
    cyc();
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b1;
    cyc();
    i_reg_rd = 1'b0;
    chk("rvld_b2b", 12'h1, {11'h0, o_reg_rvld});
    chk("rdata_b2b", {4'h0, ctl[2]}, {4'h0, o_reg_rdata});
    cyc();
    for (int n = 0; n < 400; n++) begin
      if (n % 40 == 0) begin
        i_ing_vld = 4'h0;
        i_egr_vld = 4'h0;
        for (int p = 0; p < 4; p++) begin
          ctl[p] = (n == 0) ? 8'h60 : 8'(rnd());
          wr(8'h20 + {2'(p), 4'h0}, ctl[p]);
        end
      end
      drive();
      cyc();
      check_ports();
    end
    // a reset in mid-run must clear every control word written above
    i_ing_vld = 4'h0;
    i_egr_vld = 4'h0;
    i_rst_n = 1'b0;
    repeat (3) cyc();
    i_rst_n = 1'b1;
    repeat (3) cyc();
    for (int p = 0; p < 4; p++) rd(8'h20 + {2'(p), 4'h0}, 8'h00);
    conclude();
  end
endmodule : testbench
